// ==== src/cfd_pkg.sv ====
// Purpose: Shared constants for the CPU fault detection unit
// Assumes: 32-bit AXI4-Lite register port, one aligned word per register
// Notes:   Offsets are byte addresses within the unit's window
package cfd_pkg;

  // Register byte offsets
  localparam logic [7:0] TASK_STATE_OFS     = 8'h00;
  localparam logic [7:0] SAVED_TASK_OFS     = 8'h04;
  localparam logic [7:0] INT_ENABLE_OFS     = 8'h08;
  localparam logic [7:0] FAULT_FLAG_OFS     = 8'h0c;
  localparam logic [7:0] FAULT_CLEAR_OFS    = 8'h10;
  localparam logic [7:0] CAUSE_REPORT_OFS   = 8'h14;

  // Task state fields
  localparam int TASK_GIE_BIT    = 0;
  localparam int TASK_GLOBAL_BIT = 2;
  localparam int TASK_EXT_EN_BIT = 3;
  localparam int TASK_CXM_LO     = 6;
  localparam int TASK_CXM_HI     = 7;
  localparam int TASK_ACTIVE_BIT = 10;
  localparam int SAVED_HWE_BIT   = 16;

  // Software-writable task state bits (global enable handled apart: set only)
  localparam logic [31:0] TASK_WR_MASK   = 32'h0000_04c9;
  // Bits of the task state that exist in hardware
  localparam logic [31:0] TASK_HOLD_MASK = 32'h0000_04cd;
  localparam logic [31:0] TASK_RESET     = 32'h0000_0000;
  localparam logic [31:0] SAVED_RESET    = 32'h0000_0000;

  // Interrupt enable register field
  localparam int INT_EN_NM_BIT = 1;

  // Fault flag / fault clear fields
  localparam int FLAG_EXT_BIT = 0;
  localparam int FLAG_INT_BIT = 1;
  localparam int FLAG_NMI_BIT = 2;
  localparam int FLAG_W       = 3;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Input indices of the synchronised external lines
  localparam int PIN_NMI = 0;
  localparam int PIN_EXT = 1;
  localparam int PIN_N   = 2;

endpackage

// ==== src/cfd_edge_sync.sv ====
// Purpose: Two-flop synchroniser with rising-edge pulse for one pin
// Assumes: Pin is asynchronous to clk_in
// Notes:   Edge is taken between second and third flop only
`timescale 1ns/100ps
module cfd_edge_sync (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic pin_in,
  output logic      rise_out
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // A held level gives one pulse only
  assign rise_out = sync_reg & ~prev_reg;

endmodule

// ==== src/cfd_fault_unit.sv ====
// Purpose: Fault detection and recognition unit of the CPU
// Assumes: Fault pins asynchronous; CPU-side strobes on CLK_IN
// Notes:   Registers reached over AXI4-Lite; see offsets in cfd_pkg
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
module cfd_fault_unit #(
  parameter int CAUSE_W = 8
) (
  input  wire logic               CLK_IN,
  input  wire logic               RESETN_IN,
  input  wire logic [7:0]         AWADDR_IN,
  input  wire logic               AWVALID_IN,
  output logic                    AWREADY_OUT,
  input  wire logic [31:0]        WDATA_IN,
  input  wire logic [3:0]         WSTRB_IN,
  input  wire logic               WVALID_IN,
  output logic                    WREADY_OUT,
  output logic [1:0]              BRESP_OUT,
  output logic                    BVALID_OUT,
  input  wire logic               BREADY_IN,
  input  wire logic [7:0]         ARADDR_IN,
  input  wire logic               ARVALID_IN,
  output logic                    ARREADY_OUT,
  output logic [31:0]             RDATA_OUT,
  output logic [1:0]              RRESP_OUT,
  output logic                    RVALID_OUT,
  input  wire logic               RREADY_IN,
  input  wire logic               NMI_PIN_IN,
  input  wire logic               EXTERNAL_FAULT_INPUT_IN,
  input  wire logic               INTERNAL_FAULT_IN,
  input  wire logic [CAUSE_W-1:0] INTERNAL_CAUSE_IN,
  input  wire logic               CONTEXT_SWITCH_IN,
  input  wire logic               CPU_STALL_IN,
  input  wire logic               BRANCH_DELAY_SLOT_IN,
  input  wire logic               RETURN_DONE_IN,
  output logic                    FAULT_IN_PROGRESS_OUT,
  output logic                    INTERRUPT_ACKNOWLEDGE_OUT,
  output logic                    NMI_LEGACY_REQ_OUT
);

  logic [31:0]         task_state_reg;
  logic [31:0]         saved_task_state_reg;
  logic                nonmaskable_enable_reg;
  logic [cfd_pkg::FLAG_W-1:0] fault_flag_reg;
  logic [CAUSE_W-1:0]  internal_cause_report_reg;
  logic                take_pend_reg;
  logic                ack_reg;
  logic                legacy_pend_reg;
  logic                legacy_req_reg;
  logic                active_out_reg;

  logic [7:0]          awaddr_reg;
  logic                aw_full_reg;
  logic                awready_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                w_full_reg;
  logic                wready_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                arready_reg;
  logic                rvalid_reg;
  logic [31:0]         rdata_reg;
  logic [1:0]          rresp_reg;

  logic [cfd_pkg::PIN_N-1:0] pin_async;
  logic [cfd_pkg::PIN_N-1:0] pin_rise;
  logic [31:0]         wmask;
  logic [31:0]         wval;
  logic                do_write;
  logic                wr_task;
  logic                wr_ien;
  logic                wr_clear;
  logic                wr_hit;
  logic                glob_en;
  logic                nm_set;
  logic                ext_set;
  logic                int_set;
  logic [cfd_pkg::FLAG_W-1:0] flag_set;
  logic [cfd_pkg::FLAG_W-1:0] flag_clr;
  logic                take;
  logic                legacy_deliver;
  logic [31:0]         rd_val;
  logic                rd_hit;

  assign pin_async[cfd_pkg::PIN_NMI] = NMI_PIN_IN;
  assign pin_async[cfd_pkg::PIN_EXT] = EXTERNAL_FAULT_INPUT_IN;

  for (genvar i = 0; i < cfd_pkg::PIN_N; i++) begin : g_pin
    cfd_edge_sync u_sync (
      .clk_in    (CLK_IN),
      .resetn_in (RESETN_IN),
      .pin_in    (pin_async[i]),
      .rise_out  (pin_rise[i])
    );
  end

  assign glob_en = task_state_reg[cfd_pkg::TASK_GLOBAL_BIT];

  // Write decode; a write lands once address and data are both held
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{wstrb_reg[b]}};
  end
  assign wval   = wdata_reg & wmask;
  assign wr_task  = do_write & (awaddr_reg == cfd_pkg::TASK_STATE_OFS);
  assign wr_ien   = do_write & (awaddr_reg == cfd_pkg::INT_ENABLE_OFS);
  assign wr_clear = do_write & (awaddr_reg == cfd_pkg::FAULT_CLEAR_OFS);
  // Read-only registers accept writes silently
  assign wr_hit = (awaddr_reg == cfd_pkg::TASK_STATE_OFS) | (awaddr_reg == cfd_pkg::SAVED_TASK_OFS) |
                  (awaddr_reg == cfd_pkg::INT_ENABLE_OFS) | (awaddr_reg == cfd_pkg::FAULT_FLAG_OFS) |
                  (awaddr_reg == cfd_pkg::FAULT_CLEAR_OFS) | (awaddr_reg == cfd_pkg::CAUSE_REPORT_OFS);

  // nonmaskable pin as exception once global enable set
  // external sources gated by nonmaskable enable
  assign nm_set = pin_rise[cfd_pkg::PIN_NMI] & glob_en & nonmaskable_enable_reg &
                  ~fault_flag_reg[cfd_pkg::FLAG_NMI_BIT];
  assign ext_set = pin_rise[cfd_pkg::PIN_EXT] & glob_en & nonmaskable_enable_reg &
                   task_state_reg[cfd_pkg::TASK_EXT_EN_BIT];
  // internal faults only need global enable
  // drop faults from instructions finishing in a switch
  assign int_set = INTERNAL_FAULT_IN & glob_en & ~CONTEXT_SWITCH_IN;

  always_comb begin
    flag_set = '0;
    flag_set[cfd_pkg::FLAG_NMI_BIT] = nm_set;
    flag_set[cfd_pkg::FLAG_EXT_BIT] = ext_set;
    flag_set[cfd_pkg::FLAG_INT_BIT] = int_set;
  end

  assign flag_clr = wr_clear ? wval[cfd_pkg::FLAG_W-1:0] : '0;

  // only a stall holds back a pending entry
  assign take = take_pend_reg & ~CPU_STALL_IN;

  // Legacy nonmaskable interrupt path, held off by delay slots
  assign legacy_deliver = legacy_pend_reg & ~BRANCH_DELAY_SLOT_IN & ~CPU_STALL_IN;

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      fault_flag_reg <= cfd_pkg::FLAG_RESET;
    end else begin
      fault_flag_reg <= flag_set | (fault_flag_reg & ~flag_clr);
    end
  end

  // cause kept beside the single internal flag
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      internal_cause_report_reg <= '0;
    end else if (int_set) begin
      internal_cause_report_reg <= INTERNAL_CAUSE_IN;
    end
  end

  // one entry requested on any cycle in which a flag set fires
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      take_pend_reg <= 1'b0;
      ack_reg       <= 1'b0;
    end else begin
      take_pend_reg <= (|flag_set) | (take_pend_reg & CPU_STALL_IN);
      ack_reg       <= take;
    end
  end

  // Legacy behaviour while the global enable is still clear
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      legacy_pend_reg <= 1'b0;
      legacy_req_reg  <= 1'b0;
    end else begin
      legacy_pend_reg <= (pin_rise[cfd_pkg::PIN_NMI] & ~glob_en & nonmaskable_enable_reg) |
                         (legacy_pend_reg & ~legacy_deliver);
      legacy_req_reg  <= legacy_deliver;
    end
  end

  // cleared by reset and by a taken event
  // set again by return or a written one
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      nonmaskable_enable_reg <= 1'b0;
    end else if (take | legacy_deliver) begin
      nonmaskable_enable_reg <= 1'b0;
    end else if (RETURN_DONE_IN | (wr_ien & wval[cfd_pkg::INT_EN_NM_BIT])) begin
      nonmaskable_enable_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      saved_task_state_reg <= cfd_pkg::SAVED_RESET;
    end else if (take) begin
      saved_task_state_reg <= task_state_reg | (32'h1 << cfd_pkg::SAVED_HWE_BIT);
    end
  end

  // global enable is set-only until reset
  // supervisor mode and fault activity on entry
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      task_state_reg <= cfd_pkg::TASK_RESET;
    end else if (take) begin
      task_state_reg[cfd_pkg::TASK_ACTIVE_BIT]                  <= 1'b1;
      task_state_reg[cfd_pkg::TASK_GIE_BIT]                     <= 1'b0;
      task_state_reg[cfd_pkg::TASK_CXM_HI:cfd_pkg::TASK_CXM_LO] <= 2'h0;
    end else if (RETURN_DONE_IN) begin
      task_state_reg <= (saved_task_state_reg & cfd_pkg::TASK_HOLD_MASK) |
                        (task_state_reg & (32'h1 << cfd_pkg::TASK_GLOBAL_BIT));
    end else if (wr_task) begin
      task_state_reg <= (wval & cfd_pkg::TASK_WR_MASK) |
                        (task_state_reg & (32'h1 << cfd_pkg::TASK_GLOBAL_BIT)) |
                        (wval & (32'h1 << cfd_pkg::TASK_GLOBAL_BIT));
    end
  end

  // fault activity mirrored at the boundary
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      active_out_reg <= 1'b0;
    end else begin
      active_out_reg <= task_state_reg[cfd_pkg::TASK_ACTIVE_BIT];
    end
  end

  // AXI write channels; address and data taken in either order
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      awaddr_reg  <= 8'h00;
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      w_full_reg  <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= cfd_pkg::RESP_OKAY;
    end else begin
      if (AWVALID_IN & awready_reg) begin
        awaddr_reg  <= AWADDR_IN;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end else if (!aw_full_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (WVALID_IN & wready_reg) begin
        wdata_reg  <= WDATA_IN;
        wstrb_reg  <= WSTRB_IN;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end else if (!w_full_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? cfd_pkg::RESP_OKAY : cfd_pkg::RESP_SLVERR;
      end else if (bvalid_reg & BREADY_IN) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read mux; the clear register reads as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (ARADDR_IN)
      cfd_pkg::TASK_STATE_OFS:   rd_val = task_state_reg;
      cfd_pkg::SAVED_TASK_OFS:   rd_val = saved_task_state_reg;
      cfd_pkg::INT_ENABLE_OFS:   rd_val[cfd_pkg::INT_EN_NM_BIT] = nonmaskable_enable_reg;
      cfd_pkg::FAULT_FLAG_OFS:   rd_val[cfd_pkg::FLAG_W-1:0] = fault_flag_reg;
      cfd_pkg::FAULT_CLEAR_OFS:  rd_val = 32'h0000_0000;
      cfd_pkg::CAUSE_REPORT_OFS: rd_val[CAUSE_W-1:0] = internal_cause_report_reg;
      default:                   rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= cfd_pkg::RESP_OKAY;
    end else if (ARVALID_IN & arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_val;
      rresp_reg   <= rd_hit ? cfd_pkg::RESP_OKAY : cfd_pkg::RESP_SLVERR;
    end else if (rvalid_reg & RREADY_IN) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  assign AWREADY_OUT               = awready_reg;
  assign WREADY_OUT                = wready_reg;
  assign BVALID_OUT                = bvalid_reg;
  assign BRESP_OUT                 = bresp_reg;
  assign ARREADY_OUT               = arready_reg;
  assign RVALID_OUT                = rvalid_reg;
  assign RDATA_OUT                 = rdata_reg;
  assign RRESP_OUT                 = rresp_reg;
  assign FAULT_IN_PROGRESS_OUT     = active_out_reg;
  assign INTERRUPT_ACKNOWLEDGE_OUT = ack_reg;
  assign NMI_LEGACY_REQ_OUT        = legacy_req_reg;

endmodule

// ==== verif/cfd_fault_sva.sv ====
// Purpose: Port-level assertions for the fault unit
// Assumes: Sees only the ports of cfd_fault_unit
// Notes:   Bound to the unit at the foot of this file
`timescale 1ns/100ps
module cfd_fault_sva (
  input wire logic        CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        AWREADY_OUT,
  input wire logic [1:0]  BRESP_OUT,
  input wire logic        BVALID_OUT,
  input wire logic        BREADY_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        RVALID_OUT,
  input wire logic        RREADY_IN,
  input wire logic        CPU_STALL_IN,
  input wire logic        FAULT_IN_PROGRESS_OUT,
  input wire logic        INTERRUPT_ACKNOWLEDGE_OUT,
  input wire logic        NMI_LEGACY_REQ_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_reset_quiet:
    assert property ($rose(RESETN_IN) |-> !INTERRUPT_ACKNOWLEDGE_OUT && !FAULT_IN_PROGRESS_OUT && !NMI_LEGACY_REQ_OUT)
    else $error("fault outputs active at reset release");
  a_ack_pulse:
    assert property (INTERRUPT_ACKNOWLEDGE_OUT |=> !INTERRUPT_ACKNOWLEDGE_OUT) else $error("acknowledge not one cycle");
  a_ack_fault_active:
    assert property (INTERRUPT_ACKNOWLEDGE_OUT |-> ##[0:1] FAULT_IN_PROGRESS_OUT)
    else $error("acknowledge without fault active");
  a_stall_blocks_entry:
    assert property ($past(CPU_STALL_IN) |-> !INTERRUPT_ACKNOWLEDGE_OUT) else $error("entry taken during stall");
  a_legacy_pulse:
    assert property (NMI_LEGACY_REQ_OUT |=> !NMI_LEGACY_REQ_OUT) else $error("legacy request not one cycle");
  a_bresp_hold:
    assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT)) else $error("write response dropped");
  a_rdata_hold:
    assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT)) else $error("read data dropped");
  a_aw_gap:
    assert property (BVALID_OUT && BREADY_IN |=> !AWREADY_OUT) else $error("address ready too early");
  c_ack: cover property (INTERRUPT_ACKNOWLEDGE_OUT);
  c_legacy: cover property (NMI_LEGACY_REQ_OUT);
  c_slverr: cover property (BVALID_OUT && BRESP_OUT == 2'h2);
endmodule

bind cfd_fault_unit cfd_fault_sva u_sva (.CLK_IN, .RESETN_IN, .AWREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN,
  .RDATA_OUT, .RVALID_OUT, .RREADY_IN, .CPU_STALL_IN, .FAULT_IN_PROGRESS_OUT, .INTERRUPT_ACKNOWLEDGE_OUT,
  .NMI_LEGACY_REQ_OUT);

// ==== verif/cfd_fault_src.sv ====
// Purpose: System logic that gathers error sources onto the fault lines
// Assumes: Error sources are levels on the CPU clock
// Notes:   One register stage, like a real merge tree
`timescale 1ns/100ps
module cfd_fault_src (
  input  wire logic       clk_in,
  input  wire logic [3:0] err_in,
  input  wire logic [1:0] fatal_in,
  output logic            ext_out,
  output logic            nmi_out
);
  always_ff @(posedge clk_in) begin
    ext_out <= |err_in;
    nmi_out <= |fatal_in;
  end
endmodule

// ==== verif/cfd_fault_unit_tb.sv ====
// Purpose: Self-checking bench for the fault unit
// Assumes: AXI4-Lite master here, error merge in cfd_fault_src
// Notes:   Acknowledge pulses are counted by a monitor
`timescale 1ns/100ps
module cfd_fault_unit_tb;
  logic        clk, rstn, aw_v, w_v, b_r, ar_v, r_r, int_f, ctx, stall, bds, ret;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, fip, ack, leg, nmi_pin, ext_pin;
  logic [7:0]  aw_a, ar_a, cause;
  logic [31:0] w_d, r_d;
  logic [1:0]  b_resp, r_resp, fatal;
  logic [3:0]  err;
  int          n_mismatch, cmp_count, cyc, n_ack, n_leg;

  cfd_fault_unit #(.CAUSE_W(8)) dut (.CLK_IN(clk), .RESETN_IN(rstn), .AWADDR_IN(aw_a), .AWVALID_IN(aw_v),
    .AWREADY_OUT(aw_rdy), .WDATA_IN(w_d), .WSTRB_IN(4'hf), .WVALID_IN(w_v), .WREADY_OUT(w_rdy),
    .BRESP_OUT(b_resp), .BVALID_OUT(b_v), .BREADY_IN(b_r), .ARADDR_IN(ar_a), .ARVALID_IN(ar_v),
    .ARREADY_OUT(ar_rdy), .RDATA_OUT(r_d), .RRESP_OUT(r_resp), .RVALID_OUT(r_v), .RREADY_IN(r_r),
    .NMI_PIN_IN(nmi_pin), .EXTERNAL_FAULT_INPUT_IN(ext_pin), .INTERNAL_FAULT_IN(int_f), .INTERNAL_CAUSE_IN(cause),
    .CONTEXT_SWITCH_IN(ctx), .CPU_STALL_IN(stall), .BRANCH_DELAY_SLOT_IN(bds), .RETURN_DONE_IN(ret),
    .FAULT_IN_PROGRESS_OUT(fip), .INTERRUPT_ACKNOWLEDGE_OUT(ack), .NMI_LEGACY_REQ_OUT(leg));
  cfd_fault_src src (.clk_in(clk), .err_in(err), .fatal_in(fatal), .ext_out(ext_pin), .nmi_out(nmi_pin));

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (ack === 1'b1) n_ack++;
    if (leg === 1'b1) n_leg++;
    // Hang guard, far above the planned run length
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk);
    aw_a <= a;
    w_d  <= d;
    aw_v <= 1;
    w_v  <= 1;
    b_r  <= 1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (aw_v && aw_rdy) begin
        ad = 1;
        aw_v <= 0;
      end
      if (w_v && w_rdy) begin
        wd = 1;
        w_v <= 0;
      end
    end
    do @(posedge clk); while (b_v !== 1'b1);
    b_r <= 0;
    chk("bresp", {30'h0, b_resp}, a > 8'h14 ? 32'h2 : 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1;
    r_r  <= 1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    ar_v <= 0;
    while (r_v !== 1'b1) @(posedge clk);
    r_r <= 0;
    chk(nm, r_d, e);
    chk("rresp", {30'h0, r_resp}, a > 8'h14 ? 32'h2 : 32'h0);
  endtask
  task automatic pin(input bit nmi);
    if (nmi) fatal <= 2'h2;
    else err <= 4'h8;
    repeat (6) @(posedge clk);
    fatal <= 2'h0;
    err   <= 4'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic ipulse(input logic [7:0] c);
    int_f <= 1;
    cause <= c;
    @(posedge clk);
    int_f <= 0;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, "reset value");
    wr(8'h0c, 32'h7);
    rd(8'h0c, 32'h0, "flags read only");
    wr(8'h20, 32'h1);
    rd(8'h20, 32'h0, "unmapped");
  endtask
  task automatic t_gate();
    ipulse(8'h11);
    rd(8'h0c, 32'h0, "flags without global");
    chk("ack without global", n_ack, 0);
    wr(8'h08, 32'h2);
    pin(1);
    chk("legacy request", n_leg, 1);
    rd(8'h0c, 32'h0, "no flag on legacy");
    wr(8'h00, 32'h4);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h4, "global sticky");
  endtask
  task automatic t_internal();
    stall <= 1;
    ipulse(8'h5a);
    chk("held by stall", n_ack, 0);
    stall <= 0;
    repeat (5) @(posedge clk);
    chk("internal entry", n_ack, 1);
    chk("fault output", fip, 1);
    rd(8'h0c, 32'h2, "internal flag");
    rd(8'h14, 32'h5a, "cause");
    rd(8'h04, 32'h10004, "saved state");
    rd(8'h00, 32'h404, "task state");
    wr(8'h10, 32'h0);
    rd(8'h0c, 32'h2, "clear zero");
    wr(8'h10, 32'h2);
    rd(8'h0c, 32'h0, "clear one");
    ctx <= 1;
    ipulse(8'h33);
    ctx <= 0;
    rd(8'h0c, 32'h0, "dropped in switch");
    wr(8'h00, 32'hc);
    pin(1);
    pin(0);
    rd(8'h0c, 32'h0, "pins blocked");
  endtask
  task automatic t_nmi();
    wr(8'h08, 32'h2);
    rd(8'h08, 32'h2, "enable set");
    bds <= 1;
    pin(1);
    bds <= 0;
    rd(8'h0c, 32'h4, "nonmaskable flag");
    chk("nonmaskable entry", n_ack, 2);
    rd(8'h08, 32'h0, "enable cleared");
    ret <= 1;
    @(posedge clk);
    ret <= 0;
    rd(8'h08, 32'h2, "enable on return");
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h2, "write zero ignored");
    pin(1);
    chk("pin ignored", n_ack, 2);
    wr(8'h10, 32'h4);
    rd(8'h0c, 32'h0, "nonmaskable cleared");
    // Pin edge timed so its flag set lands on the edge of the clear write
    fatal <= 2'h1;
    @(posedge clk);
    wr(8'h10, 32'h4);
    fatal <= 2'h0;
    repeat (6) @(posedge clk);
    rd(8'h0c, 32'h4, "set beats clear");
    chk("colliding entry", n_ack, 3);
    wr(8'h10, 32'h4);
  endtask
  task automatic t_ext();
    wr(8'h00, 32'hc);
    wr(8'h08, 32'h2);
    pin(0);
    rd(8'h0c, 32'h1, "external flag");
    chk("external entry", n_ack, 4);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h4);
    wr(8'h08, 32'h2);
    pin(0);
    rd(8'h0c, 32'h0, "external disabled");
  endtask

  initial begin
    {aw_v, w_v, b_r, ar_v, r_r, int_f, ctx, stall, bds, ret} = '0;
    aw_a  = 8'h0;
    ar_a  = 8'h0;
    w_d   = 32'h0;
    cause = 8'h0;
    err   = 4'h0;
    fatal = 2'h0;
    rstn = 0;
    repeat (8) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    t_reset();
    t_gate();
    t_internal();
    t_nmi();
    t_ext();
    finish_test();
  end
endmodule
